/* rtl/sel_bit_eng.sv */
// Bit-slot engine for the open-drain bus: start, stop and one data bit
module sel_bit_eng
   import sel_pkg::*;
#(
   parameter int QTR_CYC = SCL_QTR_CYC
) (
   // Clock and reset
   input  wire logic      i_core_clk,
   input  wire logic      i_srst,
   // Command
   input  wire logic      i_cmd_valid,
   input  wire sel_bcmd_t i_cmd,
   input  wire logic      i_bit,
   output logic           o_ready,
   output logic           o_done,
   output logic           o_rbit,
   // Bus lines
   input  wire logic      i_scl,
   input  wire logic      i_sda,
   output logic           o_scl_oe,
   output logic           o_sda_oe
);
   localparam logic [QCNT_W-1:0] QTR_M1 = QCNT_W'(QTR_CYC - 1);

   typedef struct packed {
      logic              scl_m;
      logic              scl_s;
      logic              sda_m;
      logic              sda_s;
      logic              busy;
      sel_bcmd_t         cmd;
      logic [1:0]        ph;
      logic [QCNT_W-1:0] cnt;
      logic              scl_oe;
      logic              sda_oe;
      logic              done;
      logic              rbit;
   } sel_eng_t;

   sel_eng_t q;
   sel_eng_t d;
   logic     step;

   always_comb begin
      d       = q;
      d.scl_m = i_scl;
      d.scl_s = q.scl_m;
      d.sda_m = i_sda;
      d.sda_s = q.sda_m;
      d.done  = 1'b0;
      // Quarter period, held in phase 1 while a slave stretches the clock
      step = (q.cnt == QTR_M1) && (q.ph != 2'd1 || q.scl_s);
      if (!q.busy) begin
         if (i_cmd_valid) begin
            d.busy = 1'b1;
            d.cmd  = i_cmd;
            d.ph   = 2'd0;
            d.cnt  = '0;
            unique case (i_cmd)
               BC_START: d.sda_oe = 1'b0;
               BC_STOP:  d.sda_oe = 1'b1;
               default:  d.sda_oe = !i_bit;
            endcase
         end
      end else if (!step) begin
         if (q.cnt != QTR_M1) begin
            d.cnt = q.cnt + 1'b1;
         end
      end else begin
         d.cnt = '0;
         d.ph  = q.ph + 2'd1;
         unique case (q.ph)
            2'd0: d.scl_oe = 1'b0;
            2'd1: begin
               if (q.cmd == BC_START) begin
                  d.sda_oe = 1'b1;
               end else if (q.cmd == BC_STOP) begin
                  d.sda_oe = 1'b0;
               end else begin
                  d.rbit = q.sda_s;
               end
            end
            2'd2: d.scl_oe = (q.cmd != BC_STOP);
            2'd3: begin
               d.busy = 1'b0;
               d.done = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_ready  = !q.busy;
   assign o_done   = q.done;
   assign o_rbit   = q.rbit;
   assign o_scl_oe = q.scl_oe;
   assign o_sda_oe = q.sda_oe;

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   a_sda_move_scl_high: assert property (
      !$stable(q.sda_oe) && !q.scl_oe && !$past(q.scl_oe) |-> q.cmd != BC_BIT)
      else $error("data line moved while clock high in a data slot");

   a_phase_quarter: assert property (
      q.busy && $past(q.busy) && q.ph != $past(q.ph) |-> $past(q.cnt) == QTR_M1)
      else $error("bus clock phase shorter than a quarter period");
endmodule

/* rtl/sel_host.sv */
// Bus host that drives the repeater's self-load pins and its register port
module sel_host
   import sel_pkg::*;
#(
   parameter logic P_STRAP_HIGH = 1'b0,
   parameter int   QTR_CYC      = SCL_QTR_CYC
) (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_srst,
   // AHB-Lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic [31:0]      o_hrdata,
   output logic             o_hresp,
   // Open-drain bus lines
   input  wire logic        i_scl,
   output logic             o_scl,
   output logic             o_scl_oe,
   input  wire logic        i_sda,
   output logic             o_sda,
   output logic             o_sda_oe,
   // Self-load handshake and strap
   output logic             o_load_req_n,
   input  wire logic        i_load_done_n,
   output logic             o_strap,
   output logic             o_strap_oe
);
   typedef struct packed {
      logic        ld_m;
      logic        ld_s;
      logic        rd;
      logic [1:0]  cnt;
      logic        ldreq;
      logic [6:0]  dev;
      logic [7:0]  regad;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic        done_f;
      logic        nack_f;
      logic        refused_f;
      sel_state_t  st;
      logic [3:0]  bitn;
      logic [7:0]  sh;
      logic [1:0]  idx;
      logic        issued;
      logic        eng_v;
      sel_bcmd_t   eng_cmd;
      logic        eng_bit;
      logic        aw_v;
      logic [7:0]  aw_addr;
      logic        hready;
      logic [31:0] hrdata;
      logic        hresp;
      logic        pin_lo;
      logic        load_req_n;
      logic        strap_oe;
   } sel_host_t;

   sel_host_t   q;
   sel_host_t   d;
   logic        eng_ready;
   logic        eng_done;
   logic        eng_rbit;
   logic        dev_busy;
   logic        byte_end;
   logic        last;
   logic [1:0]  nidx;
   logic [31:0] rdv;

   sel_bit_eng #(
      .QTR_CYC (QTR_CYC)
   ) u_eng (
      .i_core_clk  (i_core_clk),
      .i_srst      (i_srst),
      .i_cmd_valid (q.eng_v),
      .i_cmd       (q.eng_cmd),
      .i_bit       (q.eng_bit),
      .o_ready     (eng_ready),
      .o_done      (eng_done),
      .o_rbit      (eng_rbit),
      .i_scl       (i_scl),
      .i_sda       (i_sda),
      .o_scl_oe    (o_scl_oe),
      .o_sda_oe    (o_sda_oe)
   );

   always_comb begin
      d        = q;
      // While the load request bit is set, the device owns the bus until its done pin is seen low
      dev_busy = q.ldreq && q.ld_s;
      byte_end = eng_done && (q.bitn == 4'd8);
      last     = (q.idx == q.cnt);
      nidx     = q.idx + 2'd1;
      d.ld_m   = i_load_done_n;
      d.ld_s   = q.ld_m;
      d.eng_v  = 1'b0;
      d.hready = 1'b1;
      d.aw_v   = 1'b0;
      d.strap_oe = P_STRAP_HIGH;

      rdv = '0;
      unique case (i_haddr[7:0])
         OFF_CTRL: begin
            rdv[CTRL_RD]       = q.rd;
            rdv[CTRL_CNT +: 2] = q.cnt;
            rdv[CTRL_LDREQ]    = q.ldreq;
         end
         OFF_ADDR: begin
            rdv[ADDR_DEV +: 7] = q.dev;
            rdv[ADDR_REG +: 8] = q.regad;
         end
         OFF_WDATA: rdv = q.wdata;
         OFF_RDATA: rdv = q.rdata;
         OFF_STAT: begin
            rdv[STAT_BUSY] = (q.st != S_IDLE);
            rdv[STAT_DONE] = q.done_f;
            rdv[STAT_NACK] = q.nack_f;
            rdv[STAT_LDOK] = !q.ld_s;
            rdv[STAT_REFU] = q.refused_f;
         end
         default: rdv = '0;
      endcase

      // Address phase: read data is captured here for the data phase
      if (i_hsel && i_htrans[1] && i_hready) begin
         d.aw_v    = i_hwrite && (i_hsize == HSIZE_WORD);
         d.aw_addr = i_haddr[7:0];
         d.hrdata  = i_hwrite ? '0 : rdv;
      end

      // Data phase of a write; flag clears come before hardware sets
      if (q.aw_v) begin
         unique case (q.aw_addr)
            OFF_CTRL: begin
               d.ldreq = i_hwdata[CTRL_LDREQ];
               if (q.st == S_IDLE) begin
                  d.rd  = i_hwdata[CTRL_RD];
                  d.cnt = i_hwdata[CTRL_CNT +: 2];
               end
               if (i_hwdata[CTRL_GO]) begin
                  if (q.st == S_IDLE && !dev_busy) begin
                     d.st   = S_START;
                     d.idx  = '0;
                     d.bitn = '0;
                  end else begin
                     d.refused_f = 1'b1;
                  end
               end
            end
            OFF_ADDR: begin
               d.dev   = i_hwdata[ADDR_DEV +: 7];
               d.regad = i_hwdata[ADDR_REG +: 8];
            end
            OFF_WDATA: d.wdata = i_hwdata;
            OFF_STAT: begin
               d.done_f    = q.done_f && !i_hwdata[STAT_DONE];
               d.nack_f    = q.nack_f && !i_hwdata[STAT_NACK];
               d.refused_f = d.refused_f && !i_hwdata[STAT_REFU];
            end
            default: ;
         endcase
      end
      d.load_req_n = !d.ldreq;

      // Hand the next slot to the engine
      if (q.st != S_IDLE && !q.issued && eng_ready) begin
         d.issued  = 1'b1;
         d.eng_v   = 1'b1;
         d.eng_cmd = BC_BIT;
         d.eng_bit = 1'b1;
         if (q.st == S_START || q.st == S_RSTART) begin
            d.eng_cmd = BC_START;
         end else if (q.st == S_STOP) begin
            d.eng_cmd = BC_STOP;
         end else if (q.bitn != 4'd8) begin
            d.eng_bit = (q.st == S_RDATA) ? 1'b1 : q.sh[7];
         end else if (q.st == S_RDATA) begin
            d.eng_bit = last;
         end
      end

      if (eng_done) begin
         d.issued = 1'b0;
         unique case (q.st)
            S_START: begin
               d.st = S_ADDR_W;
               d.sh = {q.dev, 1'b0};
            end
            S_RSTART: begin
               d.st = S_ADDR_R;
               d.sh = {q.dev, 1'b1};
            end
            S_STOP: begin
               d.st     = S_IDLE;
               d.done_f = 1'b1;
            end
            S_ADDR_W, S_REG, S_WDATA, S_ADDR_R, S_RDATA: begin
               d.bitn = q.bitn + 4'd1;
               d.sh   = {q.sh[6:0], eng_rbit};
               if (byte_end) begin
                  d.bitn = '0;
                  d.sh   = q.sh;
                  if (q.st == S_RDATA) begin
                     d.rdata[{q.idx, 3'b000} +: 8] = q.sh;
                     d.idx = nidx;
                     if (last) begin
                        d.st = S_STOP;
                     end
                  end else if (eng_rbit) begin
                     d.st     = S_STOP;
                     d.nack_f = 1'b1;
                  end else if (q.st == S_ADDR_W) begin
                     d.st = S_REG;
                     d.sh = q.regad;
                  end else if (q.st == S_ADDR_R) begin
                     d.st  = S_RDATA;
                     d.idx = '0;
                  end else if (q.st == S_REG && q.rd) begin
                     d.st = S_RSTART;
                  end else if (q.st == S_REG || !last) begin
                     // No re-addressing: the device steps its own pointer
                     d.st  = S_WDATA;
                     d.idx = (q.st == S_REG) ? 2'd0 : nidx;
                     d.sh  = q.wdata[{d.idx, 3'b000} +: 8];
                  end else begin
                     d.st = S_STOP;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         q            <= '0;
         // Done pin idles high, so the synchroniser starts at that level
         q.ld_m       <= 1'b1;
         q.ld_s       <= 1'b1;
         q.dev        <= DEV_RST;
         q.load_req_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign o_hreadyout  = q.hready;
   assign o_hrdata     = q.hrdata;
   assign o_hresp      = q.hresp;
   assign o_scl        = q.pin_lo;
   assign o_sda        = q.pin_lo;
   assign o_load_req_n = q.load_req_n;
   assign o_strap      = q.strap_oe;
   assign o_strap_oe   = q.strap_oe;

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   a_go_while_loading: assert property (
      q.aw_v && q.aw_addr == OFF_CTRL && i_hwdata[CTRL_GO] && dev_busy && q.st == S_IDLE
      |=> q.st == S_IDLE && q.refused_f)
      else $error("transaction started while the device owned the bus");

   a_write_addr_byte: assert property (
      $changed(q.st) && q.st == S_ADDR_W |-> $past(q.st) == S_START && q.sh == {q.dev, 1'b0})
      else $error("first byte is not the address with write bit");

   a_read_after_rstart: assert property (
      $changed(q.st) && q.st == S_ADDR_R |-> $past(q.st) == S_RSTART && q.sh == {q.dev, 1'b1})
      else $error("read address not sent after repeated start");

   a_last_read_nack: assert property (
      q.eng_v && q.st == S_RDATA && q.bitn == 4'd8 |-> q.eng_bit == (q.idx == q.cnt))
      else $error("read acknowledge level wrong for byte position");

   a_nack_stops: assert property (
      byte_end && eng_rbit && q.st inside {S_ADDR_W, S_REG, S_WDATA, S_ADDR_R}
      |=> q.st == S_STOP && q.nack_f && q.bitn == 4'd0)
      else $error("not-acknowledge did not lead to stop");

   a_ptr_no_readdress: assert property (
      byte_end && !eng_rbit && q.st == S_WDATA && q.idx != q.cnt
      |=> q.st == S_WDATA && q.idx == $past(q.idx) + 2'd1 && !q.eng_v)
      else $error("next data byte not sent back to back");

   a_stop_closes: assert property (
      $changed(q.st) && q.st == S_IDLE |-> $past(q.st) == S_STOP && q.done_f)
      else $error("transaction ended without stop");

   a_strap_fixed: assert property (
      !$stable(o_strap_oe) |-> $past(i_srst, 2))
      else $error("strap drive changed during operation");

   a_ldreq_pin: assert property (
      q.aw_v && q.aw_addr == OFF_CTRL |=> o_load_req_n == !$past(i_hwdata[CTRL_LDREQ]))
      else $error("load request pin does not follow control bit");

   c_write_done: cover property ($changed(q.st) && q.st == S_IDLE && !q.rd && !q.nack_f);
   c_read_done: cover property ($changed(q.st) && q.st == S_IDLE && q.rd && !q.nack_f);
   c_nack_seen: cover property ($rose(q.nack_f));
   c_load_done: cover property (q.ldreq ##1 !q.ld_s);
endmodule

/* rtl/sel_pkg.sv */
// Shared constants and types for the repeater configuration host
package sel_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SCL_PERIOD_NS = 2500;
   localparam int SCL_QTR_NS    = SCL_PERIOD_NS / 4;
   localparam int SCL_QTR_CYC   = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int QCNT_W        = 7;
   // Host register offsets
   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_ADDR  = 8'h04;
   localparam logic [7:0] OFF_WDATA = 8'h08;
   localparam logic [7:0] OFF_RDATA = 8'h0c;
   localparam logic [7:0] OFF_STAT  = 8'h10;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // Field positions
   localparam int CTRL_GO    = 0;
   localparam int CTRL_RD    = 1;
   localparam int CTRL_CNT   = 2;
   localparam int CTRL_LDREQ = 8;
   localparam int ADDR_DEV   = 0;
   localparam int ADDR_REG   = 8;
   localparam int STAT_BUSY  = 0;
   localparam int STAT_DONE  = 1;
   localparam int STAT_NACK  = 2;
   localparam int STAT_LDOK  = 3;
   localparam int STAT_REFU  = 4;
   // Reset values
   localparam logic [6:0] DEV_RST = 7'h18;
   // Device register map and bus addresses
   localparam logic [7:0] DEV_REG_CHAN_SEL = 8'hfc;
   localparam logic [7:0] DEV_REG_PAGE_SEL = 8'hff;
   localparam int         PAGE_CHAN_BIT    = 0;
   localparam int         PAGE_QUAD_LSB    = 4;
   localparam logic [7:0] EEPROM_ADDR8     = 8'ha0;

   typedef enum logic [1:0] {BC_START, BC_STOP, BC_BIT} sel_bcmd_t;

   typedef enum logic [3:0] {
      S_IDLE, S_START, S_ADDR_W, S_REG, S_WDATA, S_RSTART, S_ADDR_R, S_RDATA, S_STOP
   } sel_state_t;
endpackage

/* tb/sel_dev_model.sv */
// Behavioural repeater device: register port slave and self-load sequence
module sel_dev_model #(
   parameter logic [6:0] P_ADDR   = 7'h18,
   parameter logic [7:0] P_ID_DEV = 8'h5b, // Arbitrary identity value
   parameter logic [7:0] P_ID_QD  = 8'h3c, // Arbitrary identity value
   parameter logic [7:0] P_SC_REG = 8'he8,
   parameter logic [7:0] P_LD_REG = 8'h10,
   parameter logic [7:0] P_LD_VAL = 8'h6d,
   parameter int         P_LD_CYC = 200
) (
   // Clock
   input  wire logic i_clk,
   // Resolved bus lines
   input  wire logic i_scl,
   input  wire logic i_sda,
   // Pins
   input  wire logic i_load_req_n,
   input  wire logic i_strap_hi,
   output logic      o_sda_oe,
   output logic      o_done_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] glob [256];
   logic [7:0] shr  [4][256];
   logic [7:0] chn  [8][256];
   logic [7:0] sh;
   logic [7:0] ptr;
   logic       act;
   logic       rd;
   logic       pend;
   logic       loaded;
   int         bn;
   int         ph;
   wire        slv = i_strap_hi | loaded;

   function automatic logic [7:0] rdreg(input logic [7:0] a);
      if (a >= 8'hef) return glob[a];
      if (glob[8'hff][0]) begin
         for (int c = 0; c < 8; c++) begin
            if (glob[8'hfc][c]) return chn[c][a];
         end
         return 8'h00;
      end
      return shr[glob[8'hff][5:4]][a];
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = (a == P_SC_REG) ? (d & 8'hfe) : d;
      if (a >= 8'hef) begin
         if (a >= 8'hf4) glob[a] = v;
      end else if (glob[8'hff][0]) begin
         for (int c = 0; c < 8; c++) begin
            if (glob[8'hfc][c]) chn[c][a] = v;
         end
      end else begin
         shr[glob[8'hff][5:4]][a] = v;
      end
   endtask

   task automatic clr_regs;
      foreach (glob[i]) glob[i] = 8'h00;
      foreach (shr[q, i]) shr[q][i] = 8'h00;
      foreach (chn[c, i]) chn[c][i] = 8'h00;
      glob[8'hef] = P_ID_QD;
      glob[8'hf1] = P_ID_DEV;
   endtask

   initial begin
      clr_regs();
      {act, rd, pend, loaded, o_sda_oe} = '0;
      bn = 0;
      ph = 0;
      sh = 8'h00;
      ptr = 8'h00;
   end

   // Open-drain done pin, pulled up outside
   assign o_done_oe = i_strap_hi ? !i_load_req_n : loaded;

   // EEPROM traffic itself is not replayed on the bus; only its effect lands
   always @(negedge i_load_req_n) begin
      if (i_strap_hi) begin
         clr_regs();
      end else if (!loaded) begin
         repeat (P_LD_CYC) @(posedge i_clk);
         shr[0][P_LD_REG] = P_LD_VAL;
         loaded = 1'b1;
      end
   end

   always @(negedge i_sda) begin
      if (i_scl && slv) begin
         act = 1'b1;
         rd = 1'b0;
         pend = 1'b0;
         bn = 0;
         ph = 0;
      end
   end

   always @(posedge i_sda) begin
      if (i_scl) begin
         act = 1'b0;
         o_sda_oe = 1'b0;
      end
   end

   always @(posedge i_scl) begin
      if (act) begin
         if (bn < 8) sh = {sh[6:0], i_sda};
         else if (rd && ph > 0 && i_sda) act = 1'b0;
         bn++;
         pend = 1'b1;
      end
   end

   always @(negedge i_scl) begin
      if (act && pend) begin
         pend = 1'b0;
         o_sda_oe = 1'b0;
         if (bn == 8 && (!rd || ph == 0)) begin
            if (ph == 0) begin
               rd = sh[0];
               act = (sh[7:1] == P_ADDR);
            end else if (ph == 1) begin
               ptr = sh;
            end else begin
               wr(ptr, sh);
               ptr++;
            end
            o_sda_oe = act;
         end else if (bn == 9) begin
            bn = 0;
            ph++;
            if (rd) begin
               sh = rdreg(ptr);
               ptr++;
            end
         end
         if (act && rd && ph > 0 && bn < 8) o_sda_oe = !sh[7];
      end
   end
endmodule

/* tb/tb_sel_host.sv */
// Self-checking bench for the configuration host against a behavioural device
module tb_sel_host
   import sel_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int         QC     = 4;
   localparam logic [6:0] DEV    = 7'h18;
   localparam logic [7:0] ID_DEV = 8'h5b; // Arbitrary identity value
   localparam logic [7:0] SC_REG = 8'he8;
   localparam logic [7:0] LD_REG = 8'h10;
   localparam logic [7:0] LD_VAL = 8'h6d;
   logic        clk, srst, hsel, hwrite, ldreq, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata, rv, st;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        scl_oe, sda_oe, dev_sda_oe, done_oe, lreq_n, strap, strap_oe, scl_drv, sda_drv;
   int          failures, cmp_count, nstart, nstop, sd;
   logic [7:0]  rst_off [6] = '{OFF_CTRL, OFF_ADDR, OFF_WDATA, OFF_RDATA, OFF_STAT, 8'h14};
   logic [31:0] rst_val [6] = '{32'h0, 32'h18, 32'h0, 32'h0, 32'h0, 32'h0};
   wire         scl_w  = !scl_oe;
   wire         sda_w  = !(sda_oe | dev_sda_oe);
   wire         done_w = !done_oe;

   sel_host #(.P_STRAP_HIGH(1'b0), .QTR_CYC(QC)) u_sel_host (
      .i_core_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
      .i_scl(scl_w), .o_scl(scl_drv), .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda(sda_drv),
      .o_sda_oe(sda_oe), .o_load_req_n(lreq_n), .i_load_done_n(done_w), .o_strap(strap),
      .o_strap_oe(strap_oe));
   sel_dev_model #(.P_ID_DEV(ID_DEV), .P_SC_REG(SC_REG), .P_LD_REG(LD_REG), .P_LD_VAL(LD_VAL))
      u_sel_dev_model (.i_clk(clk), .i_scl(scl_w), .i_sda(sda_w), .i_load_req_n(lreq_n),
      .i_strap_hi(strap & strap_oe), .o_sda_oe(dev_sda_oe), .o_done_oe(done_oe));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(negedge sda_w) if (scl_w) nstart++;
   always @(posedge sda_w) if (scl_w) nstop++;

   function automatic logic [31:0] bmask(input logic [1:0] c);
      return 32'hffffffff >> (8 * (3 - int'(c)));
   endfunction

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wrdy;
      do begin
         @(posedge clk);
      end while (hready !== 1'b1);
   endtask

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      hsize <= HSIZE_WORD;
      wrdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wrdy();
      r = hrdata;
   endtask

   task automatic smb(input logic r, input logic [6:0] dv, input logic [7:0] ra,
                      input logic [1:0] c, input logic [31:0] wd);
      ahb(1'b1, OFF_ADDR, {16'h0, ra, 1'b0, dv}, rv);
      ahb(1'b1, OFF_WDATA, wd, rv);
      nstart = 0;
      nstop = 0;
      ahb(1'b1, OFF_CTRL, {23'h0, ldreq, 4'h0, c, r, 1'b1}, rv);
      do begin
         ahb(1'b0, OFF_STAT, 32'h0, st);
      end while (st[STAT_DONE] !== 1'b1);
      ahb(1'b1, OFF_STAT, 32'h16, rv);
   endtask

   task automatic dwr(input logic [7:0] ra, input logic [1:0] c, input logic [31:0] d);
      smb(1'b0, DEV, ra, c, d);
      chk("write acknowledge", 32'(st[STAT_NACK]), 32'h0);
   endtask

   task automatic drd(input logic [7:0] ra, input logic [1:0] c, output logic [31:0] d);
      smb(1'b1, DEV, ra, c, 32'h0);
      chk("read starts", 32'(nstart), 32'h2);
      chk("read stops", 32'(nstop), 32'h1);
      ahb(1'b0, OFF_RDATA, 32'h0, d);
   endtask

   initial begin
      logic [31:0] d;
      logic [31:0] wd;
      logic [7:0]  ra;
      logic [7:0]  pg;
      logic [1:0]  c;
      srst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0;
      ldreq = 1'b0;
      failures = 0;
      cmp_count = 0;
      sd = $urandom(73);
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      foreach (rst_off[i]) begin
         ahb(1'b0, rst_off[i], 32'h0, d);
         chk("host reset value", d, rst_val[i]);
      end
      chk("strap floating", 32'(strap_oe), 32'h0);
      chk("load request idle", 32'(lreq_n), 32'h1);
      chk("pin drive values", 32'({hresp, scl_drv, sda_drv, strap}), 32'h0);
      smb(1'b1, DEV, 8'hff, 2'h0, 32'h0);
      chk("silent before load", 32'(st[STAT_NACK]), 32'h1);
      ldreq = 1'b1;
      ahb(1'b1, OFF_CTRL, 32'h100, rv);
      @(negedge clk);
      chk("load request", 32'(lreq_n), 32'h0);
      @(posedge clk);
      ahb(1'b1, OFF_CTRL, 32'h101, rv);
      ahb(1'b0, OFF_STAT, 32'h0, st);
      chk("go during load", st & 32'h11, 32'h10);
      for (int n = 0; n < 400 && st[STAT_LDOK] !== 1'b1; n++) ahb(1'b0, OFF_STAT, 32'h0, st);
      chk("load done seen", 32'(st[STAT_LDOK]), 32'h1);
      chk("done pin", 32'(done_w), 32'h0);
      ahb(1'b1, OFF_STAT, 32'h16, rv);
      drd(LD_REG, 2'h0, d);
      chk("loaded value", d & 32'hff, {24'h0, LD_VAL});
      drd(8'hff, 2'h0, d);
      chk("page kept", d & 32'hff, 32'h0);
      dwr(8'hff, 2'h0, 32'h10);
      dwr(8'h20, 2'h0, 32'ha5);
      dwr(8'hff, 2'h0, 32'h00);
      drd(8'h20, 2'h0, d);
      chk("quad isolation", d & 32'hff, 32'h0);
      dwr(8'hfc, 2'h0, 32'h02);
      dwr(8'hff, 2'h0, 32'h01);
      dwr(8'h20, 2'h0, 32'h3c);
      dwr(8'hfc, 2'h0, 32'h01);
      drd(8'h20, 2'h0, d);
      chk("channel isolation", d & 32'hff, 32'h0);
      dwr(8'hf1, 2'h0, 32'h00);
      drd(8'hf1, 2'h0, d);
      chk("identity read-only", d & 32'hff, {24'h0, ID_DEV});
      dwr(SC_REG, 2'h0, 32'hff);
      drd(SC_REG, 2'h0, d);
      chk("self-clearing bit", d & 32'hff, 32'hfe);
      smb(1'b0, 7'h19, 8'h00, 2'h0, 32'h0);
      chk("foreign address", 32'(st[STAT_NACK]), 32'h1);
      for (int i = 0; i < 6; i++) begin
         pg = {2'h0, 2'($urandom), 3'h0, 1'($urandom)};
         c = 2'($urandom);
         ra = 8'($urandom_range(224));
         wd = $urandom;
         dwr(8'hfc, 2'h0, {24'h0, 8'($urandom) | 8'h01});
         dwr(8'hff, 2'h0, {24'h0, pg});
         dwr(ra, c, wd);
         chk("write starts", 32'(nstart), 32'h1);
         drd(ra, c, d);
         chk("burst readback", d & bmask(c), wd & bmask(c));
      end
      complete_run();
   end

   initial begin
      #700us;
      failures++;
      $display("BAD watchdog expected finish seen timeout");
      complete_run();
   end
endmodule
